/* rtl/host_command_control_mode_interface.sv */
/*
  Host communication front end. Selects one of serial, parallel bus or USB
  links, runs the serial transmitter and receiver, routes command bytes and
  pushes measured-value characters to the host.
  Assumes: external USB and parallel bus engines take byte streams; all
  inputs are synchronous to core_clk; configuration is static per write.
*/
// Behaviour
// - only the selected link is ever active
// - five bit rates, 9600 default
// - 8 data bits, one stop, no parity
// - DTE; only receive and transmit carry data, modem inputs ignored
// - DTR and RTS held asserted always
// - bus address 0 to 30, default 1
// - terminator LF or CR+LF, LF default
// - keyboard external: send on trigger or key
// - keyboard internal: send on measurement end
// - USB command mode default, accepts commands
// - data output blocks commands on that link
module host_command_control_mode_interface (
  input wire logic core_clk, // Core clock 250 MHz
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic cfg_we, // Configuration write strobe
  input wire host_command_control_mode_pkg::cfg_t cfg_in, // Configuration written on cfg_we
  output host_command_control_mode_pkg::cfg_t cfg_out, // Active configuration
  input wire logic measurement_trigger_input, // Trigger pulse
  input wire logic front_panel_trigger_key, // Enter key pulse
  input wire logic meas_done, // Measurement finished pulse
  input wire host_command_control_mode_pkg::byte_t value_char, // Measured value characters
  output logic value_char_ready, // Character accepted
  output logic value_req, // Request for a value string
  output logic value_end_pend, // Terminator pending after string
  input wire logic value_last, // Last character of value string
  input wire logic ser_rxd, // Serial receive line
  output logic ser_txd, // Serial transmit line
  output logic ser_dtr, // Data terminal ready
  output logic ser_rts, // Request to send
  input wire logic ser_dcd, // Carrier detect, ignored
  input wire logic ser_dsr, // Data set ready, ignored
  input wire logic ser_cts, // Clear to send, ignored
  input wire logic ser_ri, // Ring indicator, ignored
  output logic gpib_en, // Parallel bus engine enable
  output logic usb_en, // USB engine enable
  output logic ser_en, // Serial port enable
  input wire host_command_control_mode_pkg::byte_t usb_rx, // Byte from USB engine
  input wire host_command_control_mode_pkg::byte_t gpib_rx, // Byte from bus engine
  output host_command_control_mode_pkg::byte_t usb_tx, // Byte to USB engine
  input wire logic usb_tx_ready, // USB engine takes byte
  output host_command_control_mode_pkg::byte_t cmd_byte, // Command byte to parser
  output logic command_control_mode, // Commands accepted on active link
  output logic ser_framing_err // Stop bit low on last character
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rst_s1_q, rst_s2_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire logic rst_n = rst_s2_q;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  host_command_control_mode_pkg::cfg_t cfg_q;
  host_command_control_mode_pkg::cfg_t cfg_d;

  // Illegal codes keep the stored value so the stored state is always servable
  always_comb begin
    cfg_d = cfg_in;
    if (cfg_in.link != host_command_control_mode_pkg::LINK_SERIAL && cfg_in.link != host_command_control_mode_pkg::LINK_GPIB
        && cfg_in.link != host_command_control_mode_pkg::LINK_USB) begin
      cfg_d.link = cfg_q.link;
    end
    if (cfg_in.rate > host_command_control_mode_pkg::RATE_115200) begin
      cfg_d.rate = cfg_q.rate;
    end
    if (cfg_in.gpib_addr > host_command_control_mode_pkg::GPIB_ADDR_MAX) begin
      cfg_d.gpib_addr = cfg_q.gpib_addr;
    end
    if (cfg_in.term != host_command_control_mode_pkg::TERM_LF && cfg_in.term != host_command_control_mode_pkg::TERM_CRLF) begin
      cfg_d.term = cfg_q.term;
    end
    if (cfg_in.link == host_command_control_mode_pkg::LINK_GPIB) begin
      cfg_d.data_out = 1'b0; // Data output exists on serial and USB only
    end
  end

  // Defaults: serial, 9600, address 1, LF, USB command mode, output off
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q.link <= host_command_control_mode_pkg::LINK_SERIAL;
      cfg_q.rate <= host_command_control_mode_pkg::RATE_9600;
      cfg_q.gpib_addr <= host_command_control_mode_pkg::GPIB_ADDR_RST;
      cfg_q.term <= host_command_control_mode_pkg::TERM_LF;
      cfg_q.usb_keyboard <= 1'b0;
      cfg_q.ext_trigger <= 1'b0;
      cfg_q.data_out <= 1'b0;
    end else if (cfg_we) begin
      cfg_q <= cfg_d;
    end
  end
  assign cfg_out = cfg_q;

  // ----------------------------------------------------------------
  // Link selection
  // ----------------------------------------------------------------
  // One-hot enables from a single stored code
  assign ser_en = (cfg_q.link == host_command_control_mode_pkg::LINK_SERIAL);
  assign gpib_en = (cfg_q.link == host_command_control_mode_pkg::LINK_GPIB);
  assign usb_en = (cfg_q.link == host_command_control_mode_pkg::LINK_USB);
  assign ser_dtr = host_command_control_mode_pkg::MODEM_ON;
  assign ser_rts = host_command_control_mode_pkg::MODEM_ON;

  // Streaming mode: serial or USB with data output, or USB keyboard mode
  logic stream_mode;
  assign stream_mode = (ser_en && cfg_q.data_out) || (usb_en && (cfg_q.data_out
                       || cfg_q.usb_keyboard));
  assign command_control_mode = !stream_mode;

  // ----------------------------------------------------------------
  // Bit rate divider
  // ----------------------------------------------------------------
  logic [host_command_control_mode_pkg::DIV_W-1:0] div_sel;
  always_comb begin
    case (cfg_q.rate)
      host_command_control_mode_pkg::RATE_4800: div_sel = host_command_control_mode_pkg::DIV_4800;
      host_command_control_mode_pkg::RATE_19200: div_sel = host_command_control_mode_pkg::DIV_19200;
      host_command_control_mode_pkg::RATE_38400: div_sel = host_command_control_mode_pkg::DIV_38400;
      host_command_control_mode_pkg::RATE_115200: div_sel = host_command_control_mode_pkg::DIV_115200;
      default: div_sel = host_command_control_mode_pkg::DIV_9600;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial receiver (carrier, set-ready, clear, ring lines are unused)
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;
  rx_state_t rx_state_q;
  logic [host_command_control_mode_pkg::DIV_W-1:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_shift_q;
  host_command_control_mode_pkg::byte_t ser_rx_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= 3'h0;
      rx_shift_q <= 8'h00;
      ser_rx_q <= '0;
      ser_framing_err <= 1'b0;
    end else begin
      ser_rx_q.valid <= 1'b0;
      case (rx_state_q)
        RX_IDLE: begin
          if (ser_en && !ser_rxd) begin
            rx_state_q <= RX_START;
            rx_cnt_q <= div_sel >> 1;
          end
        end
        RX_START: begin
          if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end else if (ser_rxd) begin
            rx_state_q <= RX_IDLE; // Glitch, not a start bit
          end else begin
            rx_state_q <= RX_DATA;
            rx_cnt_q <= div_sel - 1'b1;
            rx_bit_q <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end else begin
            rx_shift_q <= {ser_rxd, rx_shift_q[7:1]};
            rx_cnt_q <= div_sel - 1'b1;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'(host_command_control_mode_pkg::DATA_BITS - 1)) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 1'b1;
          end else begin
            rx_state_q <= RX_IDLE;
            ser_framing_err <= !ser_rxd;
            ser_rx_q.valid <= ser_rxd;
            ser_rx_q.data <= rx_shift_q;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command byte routing from the active link only
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_byte <= '0;
    end else begin
      cmd_byte.valid <= command_control_mode && ((ser_en && ser_rx_q.valid)
                        || (usb_en && usb_rx.valid) || (gpib_en && gpib_rx.valid));
      cmd_byte.data <= ser_en ? ser_rx_q.data : (usb_en ? usb_rx.data : gpib_rx.data);
    end
  end

  // ----------------------------------------------------------------
  // Value output sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OUT_IDLE = 2'b00,
    OUT_BODY = 2'b01,
    OUT_CR = 2'b10,
    OUT_LF = 2'b11
  } out_state_t;
  out_state_t out_q;
  logic fire;
  logic sink_ready;
  logic tx_busy;
  logic [7:0] out_data;
  logic out_valid;

  // External trigger or key, or measurement end, per trigger source
  assign fire = stream_mode && (cfg_q.ext_trigger ?
                (measurement_trigger_input || front_panel_trigger_key)
                : meas_done);
  assign sink_ready = ser_en ? !tx_busy : usb_tx_ready;
  assign out_valid = (out_q == OUT_BODY) ? value_char.valid : (out_q != OUT_IDLE);
  assign out_data = (out_q == OUT_BODY) ? value_char.data :
                    ((out_q == OUT_CR) ? host_command_control_mode_pkg::CHAR_CR : host_command_control_mode_pkg::CHAR_LF);
  assign value_char_ready = (out_q == OUT_BODY) && sink_ready;
  assign value_req = fire && (out_q == OUT_IDLE);
  assign value_end_pend = (out_q == OUT_CR) || (out_q == OUT_LF);
  wire logic out_take = out_valid && sink_ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= OUT_IDLE;
    end else begin
      case (out_q)
        OUT_IDLE: if (fire) out_q <= OUT_BODY;
        OUT_BODY: if (out_take && value_last) begin
          out_q <= (cfg_q.term == host_command_control_mode_pkg::TERM_CRLF) ? OUT_CR : OUT_LF;
        end
        OUT_CR: if (out_take) out_q <= OUT_LF;
        OUT_LF: if (out_take) out_q <= OUT_IDLE;
        default: out_q <= OUT_IDLE;
      endcase
    end
  end

  // USB sink registered
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_tx <= '0;
    end else begin
      usb_tx.valid <= usb_en && out_take;
      usb_tx.data <= out_data;
    end
  end

  // ----------------------------------------------------------------
  // Serial transmitter: start, 8 data LSB first, stop
  // ----------------------------------------------------------------
  logic [9:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic [host_command_control_mode_pkg::DIV_W-1:0] tx_cnt_q;
  assign tx_busy = (tx_left_q != 4'h0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_q <= 10'h3FF;
      tx_left_q <= 4'h0;
      tx_cnt_q <= '0;
      ser_txd <= 1'b1;
    end else if (!tx_busy) begin
      ser_txd <= 1'b1;
      if (ser_en && out_take) begin
        tx_shift_q <= {1'b1, out_data, 1'b0};
        tx_left_q <= 4'hB; // Ten bits plus one bit time so the stop bit is whole
        tx_cnt_q <= '0;
      end
    end else if (tx_cnt_q == '0) begin
      ser_txd <= tx_shift_q[0];
      tx_shift_q <= {1'b1, tx_shift_q[9:1]};
      tx_left_q <= tx_left_q - 4'h1;
      tx_cnt_q <= div_sel - 1'b1;
    end else begin
      tx_cnt_q <= tx_cnt_q - 1'b1;
    end
  end

endmodule

/* rtl/host_command_control_mode_pkg.sv */
/*
  Package for the host communication front end: interface selection codes,
  serial bit rate codes, timing constants, defaults and carrier structs.
  Assumes a 250 MHz core clock.
*/
package host_command_control_mode_pkg;

  // ----------------------------------------------------------------
  // Clock and serial timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD_4800 = 4800;
  localparam int unsigned BAUD_9600 = 9600;
  localparam int unsigned BAUD_19200 = 19200;
  localparam int unsigned BAUD_38400 = 38400;
  localparam int unsigned BAUD_115200 = 115200;
  localparam int unsigned DIV_W = 16;
  localparam logic [DIV_W-1:0] DIV_4800 = DIV_W'(CLK_HZ / BAUD_4800);
  localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'(CLK_HZ / BAUD_9600);
  localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(CLK_HZ / BAUD_19200);
  localparam logic [DIV_W-1:0] DIV_38400 = DIV_W'(CLK_HZ / BAUD_38400);
  localparam logic [DIV_W-1:0] DIV_115200 = DIV_W'(CLK_HZ / BAUD_115200);

  // ----------------------------------------------------------------
  // Framing and defaults
  // ----------------------------------------------------------------
  localparam int unsigned DATA_BITS = 8;
  localparam logic [4:0] GPIB_ADDR_MAX = 5'h1E;
  localparam logic [4:0] GPIB_ADDR_RST = 5'h01;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic MODEM_ON = 1'b1;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LINK_SERIAL = 2'b00,
    LINK_GPIB = 2'b01,
    LINK_USB = 2'b10
  } link_sel_t;

  typedef enum logic [2:0] {
    RATE_4800 = 3'b000,
    RATE_9600 = 3'b001,
    RATE_19200 = 3'b010,
    RATE_38400 = 3'b011,
    RATE_115200 = 3'b100
  } rate_sel_t;

  typedef enum logic [1:0] {
    TERM_LF = 2'b00,
    TERM_CRLF = 2'b01
  } term_sel_t;

  // Configuration carried as one group
  typedef struct packed {
    link_sel_t link;
    rate_sel_t rate;
    logic [4:0] gpib_addr;
    term_sel_t term;
    logic usb_keyboard;
    logic ext_trigger;
    logic data_out;
  } cfg_t;

  // Byte stream with handshake
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_t;

endpackage

/* bench/host_command_control_mode_properties.sv */
/*
  Checker for the host link front end, bound to its top module.
  Assumes the port names, types and constants of host_command_control_mode_pkg.
*/
module host_command_control_mode_checker (
  input wire logic core_clk, // Core clock
  input wire logic rst_b, // Reset, active low
  input wire logic cfg_we, // Config write strobe
  input wire host_command_control_mode_pkg::cfg_t cfg_in, // Config written
  input wire host_command_control_mode_pkg::cfg_t cfg_out, // Active config
  input wire logic measurement_trigger_input, // Trigger pulse
  input wire logic front_panel_trigger_key, // Key pulse
  input wire logic meas_done, // Measurement end
  input wire logic value_req, // Value string request
  input wire logic ser_txd, // Transmit line
  input wire logic ser_dtr, // Terminal ready
  input wire logic ser_rts, // Request to send
  input wire logic ser_en, // Serial enable
  input wire logic gpib_en, // Bus enable
  input wire logic usb_en, // USB enable
  input wire host_command_control_mode_pkg::byte_t usb_rx, // USB byte in
  input wire host_command_control_mode_pkg::byte_t cmd_byte, // Command byte out
  input wire logic command_control_mode // Commands open
);
  timeunit 1ns;
  timeprecision 1ps;
  logic stream;
  // Output stream occupies the active link
  assign stream = (ser_en && cfg_out.data_out) ||
    (usb_en && (cfg_out.data_out || cfg_out.usb_keyboard));
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  one_link_a:
  assert property ($onehot({ser_en, gpib_en, usb_en})) else $error("link enables not one-hot");
  link_sel_a:
  assert property (ser_en == (cfg_out.link == host_command_control_mode_pkg::LINK_SERIAL) &&
    usb_en == (cfg_out.link == host_command_control_mode_pkg::LINK_USB)) else $error("enable off config");
  modem_on_a:
  assert property (ser_dtr == host_command_control_mode_pkg::MODEM_ON && ser_rts == host_command_control_mode_pkg::MODEM_ON)
    else $error("modem outputs dropped");
  rate_ok_a:
  assert property (cfg_out.rate <= host_command_control_mode_pkg::RATE_115200) else $error("bad rate code");
  addr_load_a:
  assert property (cfg_we && cfg_in.gpib_addr <= host_command_control_mode_pkg::GPIB_ADDR_MAX |=>
    cfg_out.gpib_addr == $past(cfg_in.gpib_addr)) else $error("address not taken");
  addr_keep_a:
  assert property (cfg_we && cfg_in.gpib_addr > host_command_control_mode_pkg::GPIB_ADDR_MAX |=>
    $stable(cfg_out.gpib_addr)) else $error("illegal address taken");
  term_ok_a:
  assert property (cfg_out.term inside {host_command_control_mode_pkg::TERM_LF, host_command_control_mode_pkg::TERM_CRLF})
    else $error("bad terminator code");
  cmd_gate_a:
  assert property (command_control_mode == !stream) else $error("command gate wrong");
  usb_cmd_a:
  assert property (usb_en && command_control_mode && usb_rx.valid |=>
    cmd_byte.valid && cmd_byte.data == $past(usb_rx.data)) else $error("USB command lost");
  fire_req_a:
  assert property (value_req |-> stream && (cfg_out.ext_trigger ?
    (measurement_trigger_input || front_panel_trigger_key) : meas_done))
    else $error("value request without cause");
  start_bit_a:
  assert property ($fell(ser_txd) |-> ser_en ##1 !ser_txd [*8]) else $error("short start bit");
endmodule

bind host_command_control_mode_interface host_command_control_mode_checker u_chk (.core_clk, .rst_b, .cfg_we, .cfg_in,
  .cfg_out, .measurement_trigger_input, .front_panel_trigger_key, .meas_done, .value_req,
  .ser_txd, .ser_dtr, .ser_rts, .ser_en, .gpib_en, .usb_en, .usb_rx, .cmd_byte,
  .command_control_mode);

/* bench/host_serial.sv */
/*
  Host serial port model: sends and samples start-stop frames.
  Assumes the bench keeps bit_cyc equal to the device's bit time.
*/
module host_serial (
  input wire logic core_clk, // Core clock
  input wire logic ser_txd, // Device transmit line
  output logic ser_rxd // Device receive line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bit time in clocks; fixed at the 115200 rate, which the bench also selects in the device
  int unsigned bit_cyc = host_command_control_mode_pkg::DIV_115200;
  // Line idles at mark level
  initial ser_rxd = 1'b1;
  // One frame: low start, 8 bits LSB first, high stop, no parity
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      ser_rxd = f[i];
      repeat (bit_cyc) @(posedge core_clk);
      // Change the line just after the edge, never on it
      #1;
    end
  endtask
  // Sample each bit at its middle, bounded wait for the start
  task automatic recv(output logic [7:0] b, output logic stop);
    int n;
    n = 0;
    while (ser_txd !== 1'b0 && n < 60000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (bit_cyc / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge core_clk);
      b[i] = ser_txd;
    end
    repeat (bit_cyc) @(posedge core_clk);
    stop = ser_txd;
  endtask
endmodule

/* bench/host_command_control_mode_interface_tb.sv */
/*
  Self-checking bench for the host link front end.
  Assumes host_serial as the far serial port and the bound checker.
*/
module host_command_control_mode_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    host_command_control_mode_pkg::cfg_t i;
    host_command_control_mode_pkg::cfg_t e;
    logic [2:0] en;
  } row_t;
  logic core_clk, rst_b, cfg_we, measurement_trigger_input, front_panel_trigger_key;
  logic meas_done, value_char_ready, value_req, value_end_pend, value_last, ser_rxd, ser_txd;
  logic ser_dtr, ser_rts, ser_dcd, ser_dsr, ser_cts, ser_ri, gpib_en, usb_en, ser_en;
  logic usb_tx_ready, command_control_mode, ser_framing_err, stp;
  logic [3:0] mdm;
  logic [7:0] last_cmd, b;
  logic [7:0] txq[$];
  host_command_control_mode_pkg::cfg_t cfg_in, cfg_out;
  host_command_control_mode_pkg::byte_t value_char, usb_rx, gpib_rx, usb_tx, cmd_byte;
  int fails, n_tests, n_cmd;
  row_t rows[6];

  host_command_control_mode_interface u_dut (.core_clk, .rst_b, .cfg_we, .cfg_in, .cfg_out,
    .measurement_trigger_input, .front_panel_trigger_key, .meas_done, .value_char,
    .value_char_ready, .value_req, .value_end_pend, .value_last, .ser_rxd, .ser_txd,
    .ser_dtr, .ser_rts, .ser_dcd, .ser_dsr, .ser_cts, .ser_ri, .gpib_en, .usb_en, .ser_en,
    .usb_rx, .gpib_rx, .usb_tx, .usb_tx_ready, .cmd_byte, .command_control_mode,
    .ser_framing_err);
  host_serial u_host (.core_clk, .ser_txd, .ser_rxd);

  // ----------------------------------------------------------------
  // Clock, wandering modem lines, output monitor
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  assign {ser_dcd, ser_dsr, ser_cts, ser_ri} = mdm;
  // Count command bytes and collect USB output bytes
  always @(posedge core_clk) begin
    mdm <= mdm + 4'h3;
    if (cmd_byte.valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_byte.data;
    end
    if (usb_tx.valid === 1'b1) txq.push_back(usb_tx.data);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic host_command_control_mode_pkg::cfg_t mk(logic [1:0] l, logic [2:0] r, logic [4:0] a,
      logic [1:0] t, logic [2:0] m);
    return host_command_control_mode_pkg::cfg_t'({l, r, a, t, m});
  endfunction
  // Config write, then one cycle for cfg_out
  task automatic wcfg(input host_command_control_mode_pkg::cfg_t c);
    cfg_in = c;
    cfg_we = 1'b1;
    @(posedge core_clk) #1 cfg_we = 1'b0;
    @(posedge core_clk) #1;
  endtask
  // Hand over a value string, holding each char until taken
  task automatic push(input logic [7:0] s[$]);
    int n;
    for (int i = 0; i < s.size(); i++) begin
      value_char = '{1'b1, s[i]};
      value_last = (i == s.size() - 1);
      n = 0;
      // Ready is looked at 1 ns after an edge, then the next edge takes the char
      while (value_char_ready !== 1'b1 && n < 60000) begin
        @(posedge core_clk) #1;
        n++;
      end
      chk("char_ready", value_char_ready, 1'h1);
      @(posedge core_clk) #1;
    end
    value_char.valid = 1'b0;
    value_last = 1'b0;
  endtask
  // Bounded wait for USB bytes, then compare them
  task automatic expect_q(input logic [7:0] e[$]);
    for (int n = 0; n < 50 && txq.size() < e.size(); n++) @(posedge core_clk);
    chk("usb_count", txq.size(), e.size());
    foreach (e[i]) if (i < txq.size()) chk("usb_byte", txq[i], e[i]);
    txq.delete();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, cfg_we, measurement_trigger_input, front_panel_trigger_key, meas_done} = '0;
    {cfg_in, value_char, value_last, usb_rx, gpib_rx, mdm} = '0;
    {fails, n_tests, n_cmd} = '0;
    usb_tx_ready = 1'b1;
    rows = '{'{mk(2'h0, 3'h0, 5'h00, 2'h0, 3'h0), mk(2'h0, 3'h0, 5'h00, 2'h0, 3'h0), 3'h4},
      '{mk(2'h1, 3'h2, 5'h1E, 2'h1, 3'h1), mk(2'h1, 3'h2, 5'h1E, 2'h1, 3'h0), 3'h2},
      '{mk(2'h2, 3'h3, 5'h05, 2'h0, 3'h0), mk(2'h2, 3'h3, 5'h05, 2'h0, 3'h0), 3'h1},
      '{mk(2'h3, 3'h4, 5'h1F, 2'h2, 3'h0), mk(2'h2, 3'h4, 5'h05, 2'h0, 3'h0), 3'h1},
      '{mk(2'h0, 3'h5, 5'h01, 2'h1, 3'h0), mk(2'h0, 3'h4, 5'h01, 2'h1, 3'h0), 3'h4},
      '{mk(2'h0, 3'h1, 5'h01, 2'h0, 3'h0), mk(2'h0, 3'h1, 5'h01, 2'h0, 3'h0), 3'h4}};
    repeat (10) @(posedge core_clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    // Defaults: serial, 9600, address 1, LF, command mode, no output
    chk("defaults", {cfg_out.link, cfg_out.rate, cfg_out.gpib_addr, cfg_out.term,
      cfg_out.usb_keyboard, cfg_out.data_out}, {2'h0, 3'h1, 5'h01, 2'h0, 2'h0});
    chk("modem_idle", {ser_dtr, ser_rts, ser_txd}, 3'h7);
    // Config rows: legal codes taken, illegal ones keep the old value, bus link clears data output
    for (int i = 0; i < 6; i++) begin
      wcfg(rows[i].i);
      chk("cfg_out", cfg_out, rows[i].e);
      chk("enables", {ser_en, gpib_en, usb_en}, rows[i].en);
    end
    // USB commands back to back; bus byte on the idle link dropped
    wcfg(mk(2'h2, 3'h1, 5'h01, 2'h0, 3'h0));
    chk("cmd_mode", command_control_mode, 1'h1);
    usb_rx = '{1'b1, 8'h3A};
    gpib_rx = '{1'b1, 8'h55};
    @(posedge core_clk) #1 usb_rx.data = 8'h51;
    @(posedge core_clk) #1 {usb_rx, gpib_rx} = '0;
    @(posedge core_clk) #1;
    chk("cmd_n", n_cmd, 2);
    chk("cmd_data", last_cmd, 8'h51);
    // Keyboard, internal trigger: fires on measurement end only
    wcfg(mk(2'h2, 3'h1, 5'h01, 2'h0, 3'h4));
    chk("cmd_mode", command_control_mode, 1'h0);
    usb_rx = '{1'b1, 8'h3F};
    measurement_trigger_input = 1'b1;
    #1 chk("req_measurement_trigger_input", value_req, 1'h0);
    @(posedge core_clk) #1 usb_rx = '0;
    measurement_trigger_input = 1'b0;
    meas_done = 1'b1;
    #1 chk("req_done", value_req, 1'h1);
    @(posedge core_clk) #1 meas_done = 1'b0;
    push('{8'h31, 8'h32});
    expect_q('{8'h31, 8'h32, 8'h0A});
    chk("cmd_n", n_cmd, 2);
    // Keyboard, external trigger, CR+LF: key fires, measurement end does not
    wcfg(mk(2'h2, 3'h1, 5'h01, 2'h1, 3'h6));
    meas_done = 1'b1;
    #1 chk("req_done", value_req, 1'h0);
    @(posedge core_clk) #1 meas_done = 1'b0;
    front_panel_trigger_key = 1'b1;
    #1 chk("req_key", value_req, 1'h1);
    @(posedge core_clk) #1 front_panel_trigger_key = 1'b0;
    push('{8'h39});
    chk("end_pend", value_end_pend, 1'h1);
    // Stall the USB sink for a cycle: the terminator must wait
    usb_tx_ready = 1'b0;
    @(posedge core_clk) #1 chk("end_hold", value_end_pend, 1'h1);
    usb_tx_ready = 1'b1;
    expect_q('{8'h39, 8'h0D, 8'h0A});
    chk("end_done", value_end_pend, 1'h0);
    // Serial at 115200: host sends a command byte
    wcfg(mk(2'h0, 3'h4, 5'h01, 2'h0, 3'h0));
    u_host.send(8'hA5);
    repeat (5) @(posedge core_clk);
    #1 chk("ser_cmd", {n_cmd[7:0], last_cmd, ser_framing_err}, {8'h03, 8'hA5, 1'b0});
    // Serial data output: value then LF on the transmit line
    wcfg(mk(2'h0, 3'h4, 5'h01, 2'h0, 3'h1));
    chk("cmd_mode", command_control_mode, 1'h0);
    meas_done = 1'b1;
    @(posedge core_clk) #1 meas_done = 1'b0;
    fork
      push('{8'h37});
      begin
        u_host.recv(b, stp);
        chk("ser_tx1", {b, stp}, {8'h37, 1'b1});
        u_host.recv(b, stp);
        chk("ser_tx2", {b, stp}, {8'h0A, 1'b1});
      end
    join
    close_out();
  end

  // Watchdog: about four times the expected run of three serial frames
  initial begin
    #1_000_000;
    fails++;
    close_out();
  end
endmodule
